// file: src/ummsp_pkg.sv
// Constants, register map and state record of the multi-mode serial port.
// Assumes a single 40 MHz bus clock that also serves as the serial reference source.
package ummsp_pkg;

   // ----------
   // Register map
   // ----------
   // Printed offsets are word indices; the byte address is four times the index.
   localparam logic [7:0] IDX_DATA = 8'hf0;
   localparam logic [7:0] IDX_CTL_HI = 8'hf5;
   localparam logic [7:0] IDX_CTL_LO = 8'hf6;
   localparam logic [7:0] IDX_BAUD = 8'hf8;
   localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
   localparam logic [11:0] ADDR_CTL_HI = {2'h0, IDX_CTL_HI, 2'h0};
   localparam logic [11:0] ADDR_CTL_LO = {2'h0, IDX_CTL_LO, 2'h0};
   localparam logic [11:0] ADDR_BAUD = {2'h0, IDX_BAUD, 2'h0};
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------
   // Field positions
   // ----------
   localparam int HI_MODE_MSB = 7;
   localparam int HI_MODE_LSB = 6;
   localparam int HI_RX_ALLOW = 4;
   localparam int HI_TX_NINTH = 3;
   localparam int HI_RX_NINTH = 2;
   localparam int HI_RX_IE = 1;
   localparam int HI_RX_PEND = 0;
   localparam int LO_PARITY = 7;
   localparam int LO_CLK_MSB = 3;
   localparam int LO_CLK_LSB = 2;
   localparam int LO_TX_IE = 1;
   localparam int LO_TX_PEND = 0;

   // ----------
   // Modes, clock sources and timing
   // ----------
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h1;
   localparam logic [1:0] MODE_FIXED9 = 2'h2;
   localparam logic [1:0] MODE_ASYNC9 = 2'h3;
   // Reference clock = bus clock divided by (limit + 1).
   localparam logic [2:0] CLK_LIM_DIV1 = 3'h0;
   localparam logic [2:0] CLK_LIM_DIV2 = 3'h1;
   localparam logic [2:0] CLK_LIM_DIV4 = 3'h3;
   localparam logic [2:0] CLK_LIM_DIV8 = 3'h7;
   // Sixteen sub-ticks per bit.
   localparam logic [3:0] PHASE_MID = 4'h7;
   localparam logic [3:0] PHASE_LAST = 4'hf;
   localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] FRAME8_STOP = 4'h9;
   localparam logic [3:0] FRAME9_STOP = 4'ha;

   typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} ummsp_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_HIGH} ummsp_rx_t;

   typedef struct packed {
      // Bus slave.
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
      logic aw_got;
      logic w_got;
      logic [11:0] aw_addr;
      logic [7:0] w_byte;
      logic w_lane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      // Registers.
      logic [7:0] ctl_hi;
      logic [7:0] ctl_lo;
      logic [7:0] baud;
      logic [7:0] rx_buf;
      // Rate generation.
      logic [2:0] presc;
      logic [7:0] baud_cnt;
      // Transmit / synchronous engine.
      ummsp_tx_t tx_st;
      logic sync_rx;
      logic [10:0] tx_sh;
      logic [3:0] tx_bit;
      logic [3:0] tx_phase;
      // Asynchronous receiver.
      ummsp_rx_t rx_st;
      logic [7:0] rx_sh;
      logic [3:0] rx_bit;
      logic [3:0] rx_phase;
      // Pins and requests.
      logic out_line;
      logic in_drive;
      logic in_oe_n;
      logic rx_irq;
      logic tx_irq;
   } ummsp_state_t;

endpackage : ummsp_pkg

// file: src/ummsp_top.sv
// Multi-mode serial port: one synchronous shift mode, three asynchronous modes,
// four byte registers behind an AXI4-Lite slave.
// Assumes all inputs are synchronous to aclk and the master keeps AXI4-Lite handshakes.
//
// Overview of operation
// - Receive request needs high bit 1; transmit request needs low bit 1.
// - Every data buffer write loads transmit buffer and starts shifting.
// - Completed shift sets pending bit 0 of its register and raises request.
// - High control register at F5H, reset to 00H.
// - Low control register at F6H, reset to 00H.
// - Sync mode: receive pending set after eighth bit shifted in.
// - Mode 1: receive pending set at stop bit midpoint.
// - Modes 2 and 3: receive pending set at ninth bit midpoint.
// - Receive pending stays set until software writes zero.
// - Sync mode: transmit pending set after eighth bit shifted out.
// - Async modes: transmit pending set when stop bit starts.
// - Transmit pending stays set until software clears it.
// - Sync bit rate is reference over sixteen times divisor plus one.
// - Mode 2 bit rate is reference over sixteen, divisor ignored.
// - Modes 1 and 3 rate: reference over sixteen times divisor plus one.
// - Sync mode: data on receive pin, shift clock on transmit pin.
// - Sync mode moves 8-bit units, least significant bit first.
// - Mode field bits 7:6 equal 00B selects sync mode.
// - Low register bits 3:2 select reference clock source.
// - Low register bit 7 enables automatic transmit parity bit.
// - Sync receive starts when pending is clear and receive allow set.
// - Mode 1 frame: start zero, eight data LSB first, stop one.
// - Mode 2 sends ninth bit from high bit 3, stores received in bit 2.
// - Data reads return separate receive buffer; overrun loses a byte.
// - Async reception begins on a zero start bit while allowed.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps

module ummsp_top
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response.
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read.
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Serial pins; the input pin carries outgoing data in sync mode.
   input wire logic serial_in_pin,
   output logic serial_in_pin_out,
   output logic serial_in_pin_oe_n,
   output logic serial_out_pin,
   // Interrupt requests.
   output logic rx_irq,
   output logic tx_irq
);

   ummsp_pkg::ummsp_state_t s;
   ummsp_pkg::ummsp_state_t n;
   logic [1:0] mode;
   logic [2:0] clk_lim;
   logic [7:0] div;
   logic ref_tick;
   logic tick16;
   logic do_wr;
   logic wr_hit;
   logic wr_data;
   logic ninth;
   logic [3:0] stop_bit;

   // ----------
   // Next-state logic
   // ----------

   // Everything is computed into one copy of the state record.
   always_comb
   begin
      n = s;
      mode = s.ctl_hi[ummsp_pkg::HI_MODE_MSB:ummsp_pkg::HI_MODE_LSB];
      wr_hit = 1'b0;
      wr_data = 1'b0;

      // Reference clock source from the bus clock.
      case (s.ctl_lo[ummsp_pkg::LO_CLK_MSB:ummsp_pkg::LO_CLK_LSB])
         2'h0: clk_lim = ummsp_pkg::CLK_LIM_DIV1;
         2'h1: clk_lim = ummsp_pkg::CLK_LIM_DIV2;
         2'h2: clk_lim = ummsp_pkg::CLK_LIM_DIV4;
         default: clk_lim = ummsp_pkg::CLK_LIM_DIV8;
      endcase
      ref_tick = (s.presc >= clk_lim);
      n.presc = ref_tick ? 3'h0 : s.presc + 3'h1;

      // Sixteen-times rate tick: the fixed mode bypasses the divisor.
      div = (mode == ummsp_pkg::MODE_FIXED9) ? 8'h00 : s.baud;
      tick16 = 1'b0;
      if (ref_tick)
      begin
         if (s.baud_cnt >= div)
         begin
            n.baud_cnt = 8'h00;
            tick16 = 1'b1;
         end
         else
         begin
            n.baud_cnt = s.baud_cnt + 8'h01;
         end
      end

      // Write channels are taken independently, then applied together.
      if (awvalid && s.aw_rdy)
      begin
         n.aw_got = 1'b1;
         n.aw_addr = awaddr;
      end
      if (wvalid && s.w_rdy)
      begin
         n.w_got = 1'b1;
         n.w_byte = wdata[7:0];
         n.w_lane = wstrb[0];
      end
      if (s.bvalid && bready)
         n.bvalid = 1'b0;
      do_wr = s.aw_got && s.w_got && !s.bvalid;
      if (do_wr)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         wr_hit = 1'b1;
         case (s.aw_addr)
            ummsp_pkg::ADDR_DATA: wr_data = s.w_lane;
            ummsp_pkg::ADDR_CTL_HI:
               if (s.w_lane)
                  n.ctl_hi = s.w_byte;
            ummsp_pkg::ADDR_CTL_LO:
               if (s.w_lane)
                  n.ctl_lo = s.w_byte;
            ummsp_pkg::ADDR_BAUD:
               if (s.w_lane)
                  n.baud = s.w_byte;
            default: wr_hit = 1'b0;
         endcase
         n.bresp = wr_hit ? ummsp_pkg::RESP_OKAY : ummsp_pkg::RESP_DECERR;
      end
      n.aw_rdy = !n.aw_got && !n.bvalid;
      n.w_rdy = !n.w_got && !n.bvalid;

      // Reads have no side effects; unmapped addresses answer with a decode error.
      if (s.rvalid && rready)
         n.rvalid = 1'b0;
      if (arvalid && s.ar_rdy)
      begin
         n.rvalid = 1'b1;
         n.rresp = ummsp_pkg::RESP_OKAY;
         case (araddr)
            ummsp_pkg::ADDR_DATA: n.rdata = s.rx_buf;
            ummsp_pkg::ADDR_CTL_HI: n.rdata = s.ctl_hi;
            ummsp_pkg::ADDR_CTL_LO: n.rdata = s.ctl_lo;
            ummsp_pkg::ADDR_BAUD: n.rdata = s.baud;
            default:
            begin
               n.rdata = 8'h00;
               n.rresp = ummsp_pkg::RESP_DECERR;
            end
         endcase
      end
      n.ar_rdy = !n.rvalid;

      // Ninth bit is either software's value or even parity of the byte.
      ninth = s.ctl_lo[ummsp_pkg::LO_PARITY] ? ^s.w_byte
            : s.ctl_hi[ummsp_pkg::HI_TX_NINTH];
      stop_bit = (mode == ummsp_pkg::MODE_ASYNC8) ? ummsp_pkg::FRAME8_STOP
               : ummsp_pkg::FRAME9_STOP;

      // Transmit and synchronous shift engine.
      case (s.tx_st)
         ummsp_pkg::TX_ASYNC:
         begin
            if (tick16)
            begin
               n.tx_phase = s.tx_phase + 4'h1;
               if (s.tx_phase == ummsp_pkg::PHASE_LAST)
               begin
                  n.tx_bit = s.tx_bit + 4'h1;
                  n.tx_sh = {1'b1, s.tx_sh[10:1]};
                  if (s.tx_bit == stop_bit)
                     n.tx_st = ummsp_pkg::TX_IDLE;
                  else if (n.tx_bit == stop_bit)
                     n.ctl_lo[ummsp_pkg::LO_TX_PEND] = 1'b1;
               end
            end
         end
         ummsp_pkg::TX_SYNC:
         begin
            if (tick16)
            begin
               n.tx_phase = s.tx_phase + 4'h1;
               // Rising shift clock edge: sample the data pin.
               if (s.tx_phase == ummsp_pkg::PHASE_MID && s.sync_rx)
                  n.rx_sh = {serial_in_pin, s.rx_sh[7:1]};
               if (s.tx_phase == ummsp_pkg::PHASE_LAST)
               begin
                  n.tx_bit = s.tx_bit + 4'h1;
                  n.tx_sh = {1'b1, s.tx_sh[10:1]};
                  if (s.tx_bit == ummsp_pkg::SYNC_LAST_BIT)
                  begin
                     n.tx_st = ummsp_pkg::TX_IDLE;
                     if (s.sync_rx)
                     begin
                        n.rx_buf = s.rx_sh;
                        n.ctl_hi[ummsp_pkg::HI_RX_PEND] = 1'b1;
                     end
                     else
                        n.ctl_lo[ummsp_pkg::LO_TX_PEND] = 1'b1;
                  end
               end
            end
         end
         default:
         begin
            // Sync receive waits for a clear pending flag so a byte is never overrun.
            if (mode == ummsp_pkg::MODE_SYNC && s.ctl_hi[ummsp_pkg::HI_RX_ALLOW]
                && !s.ctl_hi[ummsp_pkg::HI_RX_PEND])
            begin
               n.tx_st = ummsp_pkg::TX_SYNC;
               n.sync_rx = 1'b1;
               n.tx_bit = 4'h0;
               n.tx_phase = 4'h0;
            end
         end
      endcase

      // A data write always restarts transmission, even mid-frame.
      if (wr_data)
      begin
         n.tx_bit = 4'h0;
         n.tx_phase = 4'h0;
         if (mode == ummsp_pkg::MODE_SYNC)
         begin
            n.tx_st = ummsp_pkg::TX_SYNC;
            n.sync_rx = 1'b0;
            n.tx_sh = {3'h7, s.w_byte};
         end
         else if (mode == ummsp_pkg::MODE_ASYNC8)
         begin
            n.tx_st = ummsp_pkg::TX_ASYNC;
            n.tx_sh = {2'h3, s.w_byte, 1'b0};
         end
         else
         begin
            n.tx_st = ummsp_pkg::TX_ASYNC;
            n.tx_sh = {1'b1, ninth, s.w_byte, 1'b0};
         end
      end

      // Asynchronous receiver, held idle in sync mode or when not allowed.
      if (mode == ummsp_pkg::MODE_SYNC || !s.ctl_hi[ummsp_pkg::HI_RX_ALLOW])
         n.rx_st = ummsp_pkg::RX_IDLE;
      else
      begin
         case (s.rx_st)
            ummsp_pkg::RX_IDLE:
            begin
               if (!serial_in_pin)
               begin
                  n.rx_st = ummsp_pkg::RX_START;
                  n.rx_phase = 4'h0;
               end
            end
            ummsp_pkg::RX_START:
            begin
               if (tick16)
               begin
                  n.rx_phase = s.rx_phase + 4'h1;
                  // A start bit gone high at its midpoint was a glitch.
                  if (s.rx_phase == ummsp_pkg::PHASE_MID && serial_in_pin)
                     n.rx_st = ummsp_pkg::RX_IDLE;
                  else if (s.rx_phase == ummsp_pkg::PHASE_LAST)
                  begin
                     n.rx_st = ummsp_pkg::RX_DATA;
                     n.rx_bit = 4'h0;
                  end
               end
            end
            ummsp_pkg::RX_DATA:
            begin
               if (tick16)
               begin
                  n.rx_phase = s.rx_phase + 4'h1;
                  if (s.rx_phase == ummsp_pkg::PHASE_LAST)
                     n.rx_bit = s.rx_bit + 4'h1;
                  if (s.rx_phase == ummsp_pkg::PHASE_MID)
                  begin
                     if (s.rx_bit < ummsp_pkg::DATA_BITS)
                        n.rx_sh = {serial_in_pin, s.rx_sh[7:1]};
                     else
                     begin
                        // Stop bit (mode 1) or ninth bit (modes 2, 3); stop is ignored.
                        n.rx_st = ummsp_pkg::RX_HIGH;
                        n.rx_buf = s.rx_sh;
                        n.ctl_hi[ummsp_pkg::HI_RX_PEND] = 1'b1;
                        if (mode != ummsp_pkg::MODE_ASYNC8)
                           n.ctl_hi[ummsp_pkg::HI_RX_NINTH] = serial_in_pin;
                     end
                  end
               end
            end
            ummsp_pkg::RX_HIGH:
            begin
               // Wait for an idle line so a low ninth bit is not a new start.
               if (serial_in_pin)
                  n.rx_st = ummsp_pkg::RX_IDLE;
            end
            default: n.rx_st = ummsp_pkg::RX_IDLE;
         endcase
      end

      // Pins: sync mode drives the shift clock, idle high, low in each bit's first half.
      if (n.tx_st == ummsp_pkg::TX_SYNC)
      begin
         n.out_line = n.tx_phase[3];
         n.in_drive = n.tx_sh[0];
         n.in_oe_n = n.sync_rx;
      end
      else
      begin
         n.out_line = (n.tx_st == ummsp_pkg::TX_ASYNC) ? n.tx_sh[0] : 1'b1;
         n.in_drive = 1'b1;
         n.in_oe_n = 1'b1;
      end

      // Requests follow the pending flags gated by their enables.
      n.rx_irq = n.ctl_hi[ummsp_pkg::HI_RX_PEND] && n.ctl_hi[ummsp_pkg::HI_RX_IE];
      n.tx_irq = n.ctl_lo[ummsp_pkg::LO_TX_PEND] && n.ctl_lo[ummsp_pkg::LO_TX_IE];
   end

   // ----------
   // State register
   // ----------

   // Synchronous reset puts every field at a constant.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.aw_rdy <= 1'b1;
         s.w_rdy <= 1'b1;
         s.ar_rdy <= 1'b1;
         s.ctl_hi <= ummsp_pkg::CTL_RESET;
         s.ctl_lo <= ummsp_pkg::CTL_RESET;
         s.baud <= ummsp_pkg::BAUD_RESET;
         s.tx_st <= ummsp_pkg::TX_IDLE;
         s.rx_st <= ummsp_pkg::RX_IDLE;
         s.out_line <= 1'b1;
         s.in_drive <= 1'b1;
         s.in_oe_n <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // ----------
   // Outputs, all straight from the state register
   // ----------
   assign awready = s.aw_rdy;
   assign wready = s.w_rdy;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.ar_rdy;
   assign rvalid = s.rvalid;
   assign rdata = {24'h000000, s.rdata};
   assign rresp = s.rresp;
   assign serial_in_pin_out = s.in_drive;
   assign serial_in_pin_oe_n = s.in_oe_n;
   assign serial_out_pin = s.out_line;
   assign rx_irq = s.rx_irq;
   assign tx_irq = s.tx_irq;

endmodule : ummsp_top

// file: test/ummsp_assertions.sv
// Checker of the bus handshakes and requests of the serial port.
// Assumes it is bound into ummsp_top and sees only its ports.
`timescale 1ns/10ps

module ummsp_assertions
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Pins and requests.
   input wire logic serial_out_pin,
   input wire logic rx_irq,
   input wire logic tx_irq
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Both write channels taken at one edge.
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   // One cycle to register, then the answer.
   sequence s_wr_answer;
      !bvalid ##1 bvalid;
   endsequence

   AST_RESET_IDLE: assert property (
      $rose(aresetn) |-> serial_out_pin && !rx_irq && !tx_irq)
      else $error("pins or requests not idle after reset");
   AST_WR_LATENCY: assert property (s_wr_take |=> s_wr_answer)
      else $error("write answer not two cycles after the handshake");
   AST_WR_BLOCK: assert property (s_wr_take |=> !awready && !wready)
      else $error("write channels ready while a write is open");
   AST_B_CLEAR: assert property (bvalid && bready |=> !bvalid && awready && wready)
      else $error("write response not closed after its handshake");
   AST_R_NEXT: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer not one cycle after the address");
   AST_R_CLEAR: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer not closed after its handshake");
   AST_RDATA_HI: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   // A flag only drops while software writes, since hardware never clears it.
   AST_TX_HOLD: assert property (
      $fell(tx_irq) |-> !(awready && $past(awready) && $past(awready, 2)))
      else $error("transmit request dropped without a write");
   AST_RX_HOLD: assert property (
      $fell(rx_irq) |-> !(awready && $past(awready) && $past(awready, 2)))
      else $error("receive request dropped without a write");
endmodule : ummsp_assertions

bind ummsp_top ummsp_assertions chk_u
(
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
   .arready, .rvalid, .rready, .rdata, .serial_out_pin, .rx_irq, .tx_irq
);

// file: test/ummsp_far_end.sv
// Remote serial device: sends asynchronous frames or clocked bytes to the port.
// Assumes the bench merges its line with the port's drive on the receive pin.
`timescale 1ns/10ps

module ummsp_far_end
(
   // Clock.
   input wire logic aclk,
   // Shift clock from the port.
   input wire logic shift_clk,
   // Level offered on the receive pin.
   output logic line
);
   logic [7:0] sh = 8'h00;
   logic armed = 1'b0;
   int cnt = 0;

   // An asynchronous line idles at mark.
   initial
      line = 1'b1;

   // Sends n frame bits, lowest first, each for bt cycles.
   task automatic send_async(input logic [10:0] fr, input int n, input int bt);
      for (int i = 0; i < n; i++)
      begin
         line <= fr[i];
         repeat (bt) @(posedge aclk);
      end
   endtask : send_async

   // Prepares a byte for the port's shift clock.
   task automatic arm_sync(input logic [7:0] b);
      sh = b;
      cnt = 0;
      armed = 1'b1;
   endtask : arm_sync

   // A new bit follows each falling edge, so it is settled at the rising one.
   always @(negedge shift_clk)
   begin
      if (armed)
         line <= sh[cnt];
   end

   // After the eighth rising edge the line is let go and shows a wrong level.
   always @(posedge shift_clk)
   begin
      if (armed)
      begin
         cnt <= cnt + 1;
         if (cnt == 7)
         begin
            armed <= 1'b0;
            line <= ~sh[7];
         end
      end
   end
endmodule : ummsp_far_end

// file: test/ummsp_tb_top.sv
// Self-checking bench of the multi-mode serial port.
// Assumes every bus task is entered right after a rising edge of aclk.
`timescale 1ns/10ps

module ummsp_tb_top;
   // ----
   // Signals and instances
   // ----
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, rx_irq, tx_irq, far_line;
   logic serial_out_pin, serial_in_pin, serial_in_pin_out, serial_in_pin_oe_n;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;

   // The 40 MHz bus clock.
   always #12.5 aclk = ~aclk;

   // The pin shows the port's data while it drives, else the remote's.
   assign serial_in_pin = serial_in_pin_oe_n ? far_line : serial_in_pin_out;

   // Port and remote device.
   ummsp_top dut_u
   (
      .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
      .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
      .rvalid, .rready, .rdata, .rresp, .serial_in_pin, .serial_in_pin_out,
      .serial_in_pin_oe_n, .serial_out_pin, .rx_irq, .tx_irq
   );
   ummsp_far_end far_u (.aclk(aclk), .shift_clk(serial_out_pin), .line(far_line));

   // ----
   // Tasks
   // ----
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Both channels offered together; each is dropped once taken.
   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw_done = 1'b0;
      logic w_done = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         aw_done = aw_done | awready;
         w_done = w_done | wready;
         awvalid <= !aw_done;
         wvalid <= !w_done;
      end
      while (bvalid !== 1'b1)
         @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
      // One edge apart, so a following call never drives bready twice in a step.
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
         @(posedge aclk);
      while (arready !== 1'b1);
      arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk(r, ummsp_pkg::RESP_OKAY);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(r, ummsp_pkg::RESP_OKAY);
      chk(d, exp);
   endtask : rd_chk

   // Samples an asynchronous frame at the middle of each bit.
   task automatic tx_frame(input logic [7:0] d, input int nb, input int bt, input logic nin,
                           input logic ie);
      int k;
      for (k = 0; k < 4000 && serial_out_pin !== 1'b0; k++)
         @(posedge aclk);
      repeat (bt / 2) @(posedge aclk);
      chk(serial_out_pin, 1'b0);
      for (k = 0; k < nb; k++)
      begin
         repeat (bt) @(posedge aclk);
         chk(serial_out_pin, (k == 8) ? nin : d[k]);
      end
      chk(tx_irq, 1'b0);
      repeat (bt) @(posedge aclk);
      chk(serial_out_pin, 1'b1);
      chk(tx_irq, ie);
   endtask : tx_frame

   // A hang ends the run as a failure.
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         final_report();
      end
   end

   // ----
   // Main sequence
   // ----
   localparam logic [11:0] DT = ummsp_pkg::ADDR_DATA;
   localparam logic [11:0] HI = ummsp_pkg::ADDR_CTL_HI;
   localparam logic [11:0] LO = ummsp_pkg::ADDR_CTL_LO;
   localparam logic [11:0] BD = ummsp_pkg::ADDR_BAUD;
   initial
   begin
      logic [31:0] rd;
      logic [1:0] rs;
      logic [1:0] c;
      logic [7:0] d;
      logic [7:0] got;
      logic nin;
      logic ie;
      logic p;
      int bt;
      void'($urandom(239));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(HI, 32'h0);
      rd_chk(LO, 32'h0);
      axi_rd(12'h004, rd, rs);
      chk(rs, ummsp_pkg::RESP_DECERR);
      axi_wr(12'h008, 8'hff, rs);
      chk(rs, ummsp_pkg::RESP_DECERR);
      d = 8'($urandom);
      wr(BD, d);
      rd_chk(BD, {24'h0, d});
      wr(BD, 8'h01);
      $display("test registers done");
      // Parity on or off at random: when on, the ninth bit is the even parity of the byte.
      for (int m = 1; m < 4; m++)
      begin
         nin = 1'($urandom);
         p = 1'($urandom);
         ie = (m != 3);
         d = 8'($urandom);
         c = 2'(m - 1);
         bt = 16 * (1 << (m - 1)) * ((m == 2) ? 1 : 2);
         wr(LO, {p, 3'h0, c, ie, 1'b0});
         wr(HI, {2'(m), 2'b00, nin, 3'b000});
         wr(DT, d);
         tx_frame(d, (m == 1) ? 8 : 9, bt, p ? ^d : nin, ie);
         rd_chk(LO, {24'h0, p, 3'h0, c, ie, 1'b1});
         chk(tx_irq, ie);
         wr(LO, {p, 3'h0, c, ie, 1'b0});
         repeat (2) @(posedge aclk);
         chk(tx_irq, 1'b0);
      end
      $display("test async transmit done");
      wr(LO, 8'h00);
      for (int m = 1; m < 4; m++)
      begin
         nin = 1'($urandom);
         d = (m == 1) ? 8'h80 : 8'($urandom);
         wr(HI, {2'(m), 6'h12});
         far_u.send_async({1'b1, (m == 1) | nin, d, 1'b0}, 11 - (m == 1), 16 * (1 + (m != 2)));
         chk(rx_irq, 1'b1);
         rd_chk(DT, {24'h0, d});
         if (m != 1)
            rd_chk(HI, {24'h0, 2'(m), 3'b010, nin, 2'b11});
         wr(HI, {2'(m), 6'h12});
         repeat (2) @(posedge aclk);
         chk(rx_irq, 1'b0);
      end
      $display("test async receive done");
      wr(HI, 8'h00);
      wr(LO, 8'h02);
      d = 8'($urandom);
      wr(DT, d);
      for (int i = 0; i < 8; i++)
      begin
         chk(tx_irq, 1'b0);
         @(posedge serial_out_pin);
         got[i] = serial_in_pin;
         chk(serial_in_pin_oe_n, 1'b0);
      end
      repeat (40) @(posedge aclk);
      chk(got, d);
      chk(tx_irq, 1'b1);
      chk(serial_in_pin_oe_n, 1'b1);
      wr(LO, 8'h00);
      $display("test sync transmit done");
      d = 8'($urandom);
      far_u.arm_sync(d);
      wr(HI, 8'h12);
      for (int i = 0; i < 2000 && rx_irq !== 1'b1; i++)
         @(posedge aclk);
      chk(rx_irq, 1'b1);
      rd_chk(DT, {24'h0, d});
      wr(HI, 8'h00);
      $display("test sync receive done");
      final_report();
   end
endmodule : ummsp_tb_top
